// *** scm_consts.svh ***
// register offsets, field positions, reset values and timing counts of the serial mode control block
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

`define SCM_OFS_MODE_A      4'h0
`define SCM_OFS_MODE_B      4'h4
`define SCM_OFS_STATUS      4'h8

`define SCM_A_TX9           7
`define SCM_A_HANDSHAKE_ENABLE          6
`define SCM_A_RXE           5
`define SCM_A_WU            4
`define SCM_A_SM_HI         3
`define SCM_A_SM_LO         2
`define SCM_A_SC_HI         1
`define SCM_A_SC_LO         0

`define SCM_B_IDLE          7
`define SCM_B_DPX_HI        6
`define SCM_B_DPX_LO        5
`define SCM_B_TXE           4
`define SCM_B_GAP_HI        3
`define SCM_B_GAP_LO        1
`define SCM_B_SPARE         0

`define SCM_S_RX9           0
`define SCM_S_GAP           1
`define SCM_S_TXOK          2
`define SCM_S_RXOK          3
`define SCM_S_CTS           4

`define SCM_MODE_A_RST      8'h00
`define SCM_MODE_B_RST      8'h00
`define SCM_CLK_PERIOD_NS   4
`define SCM_GAP_MAX         64

`endif

// *** scm_gap_timer.sv ***
// idle gap timer between back-to-back synchronous transfers
`timescale 1ns/1ps
`default_nettype none

module scm_gap_timer #(
	parameter int CNT_W = 7
) (
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       start_i,
	input  wire logic [2:0] code_i,
	input  wire logic       tick_i,
	output logic            hold_o
);
	import scm_pkg::*;

	scm_gap_state_t   state;
	logic [CNT_W-1:0] left;
	logic [6:0]       cycles;

	if (CNT_W < 7) begin : g_bad_width
		$error("scm_gap_timer: CNT_W too small for 64 cycles");
	end

	assign cycles = scm_gap_cycles(code_i);
	assign hold_o = (state == SCM_GAP_WAIT);

	// counts serial clock cycles, not system cycles [R11]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= SCM_GAP_IDLE;
			left  <= '0;
		end else begin
			unique case (state)
				SCM_GAP_IDLE: begin
					if (start_i && cycles != 7'h00) begin
						state <= SCM_GAP_WAIT;
						left  <= CNT_W'(cycles);
					end
				end
				SCM_GAP_WAIT: begin
					if (tick_i) begin
						left <= left - CNT_W'(1);
						if (left == CNT_W'(1)) begin
							state <= SCM_GAP_IDLE;
						end
					end
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// *** scm_mode_ctrl.sv ***
// serial channel mode control: mode registers on an Avalon-MM slave and the gating they steer
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.svh"

// Behaviour
// [R01] in 9-bit UART mode the stored ninth transmit bit is sent with each character
// [R02] in UART modes handshake enable gates transmission on clear-to-send, else ignored
// [R03] wake-up in 9-bit mode raises receive interrupt only when ninth bit is 1
// [R04] frame mode field: 00 synchronous, 01 7-bit, 10 8-bit, 11 9-bit UART
// [R05] UART clock select: 00 timer, 01 baud generator, 10 system clock, 11 pin
// [R06] synchronous mode ignores UART clock select, uses control register clock direction
// [R07] idle operate: 0 stops the channel in idle, 1 keeps it running
// [R08] synchronous duplex: 00 none, 01 receive, 10 transmit, 11 full; sets FIFO layout
// [R09] in UART modes duplex only sets FIFO layout, never blocks a direction
// [R10] transmit enable and receive enable allow their direction when 1
// [R11] gap field inserts 0,1,2,4,8,16,32 or 64 serial clock cycles between transmissions
// [R12] gap only in synchronous mode, clock driven here, buffering or FIFO on
// [R13] software sets all mode fields before enabling reception
// [R14] software sets all mode fields before enabling transmission
// [R15] software does not clear receive enable during a character
// [R16] software does not clear transmit enable during a character
// [R17] synchronous clock direction 0 drives the serial clock pin, 1 accepts it
// [R18] in 9-bit UART mode the received ninth bit is readable by software
// [R19] bits 31 to 8 of both mode registers read zero and ignore writes
// [R20] software writes zero to bit 0 of the second mode register
module scm_mode_ctrl (
	input  wire logic                clock_i,
	input  wire logic                rstn_i,
	input  wire logic [3:0]          avs_address_i,
	input  wire logic                avs_read_i,
	input  wire logic                avs_write_i,
	input  wire logic [31:0]         avs_writedata_i,
	input  wire logic [3:0]          avs_byteenable_i,
	output logic      [31:0]         avs_readdata_o,
	output logic                     avs_waitrequest_o,
	input  wire logic                clock_direction_i,
	input  wire logic                idle_mode_i,
	input  wire logic                buffered_i,
	input  wire logic                timer_output_source_i,
	input  wire logic                baud_tick_i,
	input  wire logic                io_sclk_i,
	input  wire logic                clear_to_send_pin_n_i,
	input  wire logic                serial_clock_pin_i,
	output logic                     serial_clock_pin_o,
	output logic                     serial_clock_pin_oe_o,
	input  wire logic                tx_done_i,
	input  wire logic                rx_char_done_i,
	input  wire logic                rx_ninth_bit_i,
	output scm_pkg::scm_frame_t      frame_mode_o,
	output scm_pkg::scm_duplex_t     fifo_config_o,
	output logic                     tx_ninth_bit_o,
	output logic                     tx_allow_o,
	output logic                     rx_allow_o,
	output logic                     xfer_tick_o,
	output logic                     rx_irq_o
);
	import scm_pkg::*;

	logic [7:0]  mode_a;
	logic [7:0]  mode_b;
	logic        received_ninth_bit;
	logic        bus_done;
	logic        bus_req;
	logic [1:0]  pin_sync;
	logic        cts_n_sync;
	logic        sclk_pin_sync;
	logic        sclk_pin_prev;
	logic        io_sclk_prev;
	logic        sclk_pin_rise;
	logic        io_sclk_rise;
	scm_frame_t  frame;
	scm_uclk_t   uart_clk;
	scm_duplex_t duplex;
	logic        is_io;
	logic        channel_run;
	logic        cts_ok;
	logic        gap_apply;
	logic        gap_hold;
	logic        next_tx_allow;
	logic        next_rx_allow;
	logic        next_tick;
	logic        next_irq;
	logic [31:0] next_rdata;

	assign frame    = scm_frame_t'(mode_a[`SCM_A_SM_HI:`SCM_A_SM_LO]);
	assign uart_clk = scm_uclk_t'(mode_a[`SCM_A_SC_HI:`SCM_A_SC_LO]);
	assign duplex   = scm_duplex_t'(mode_b[`SCM_B_DPX_HI:`SCM_B_DPX_LO]);
	assign is_io    = (frame == SCM_FRAME_IO); // [R04]

	// Avalon slave: one wait cycle on every access, readdata set up before it is sampled
	assign bus_req           = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = bus_req & ~bus_done;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_done <= 1'b0;
		end else begin
			bus_done <= bus_req & ~bus_done;
		end
	end

	// only the low byte is stored, upper bits never exist [R19]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_a <= `SCM_MODE_A_RST;
			mode_b <= `SCM_MODE_B_RST;
		end else if (avs_write_i && bus_done && avs_byteenable_i[0]) begin
			if (avs_address_i == `SCM_OFS_MODE_A) begin
				mode_a <= avs_writedata_i[7:0];
			end
			if (avs_address_i == `SCM_OFS_MODE_B) begin
				// spare bit 0 is kept for readback only; it steers nothing [R20]
				mode_b <= avs_writedata_i[7:0];
			end
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (avs_address_i)
			`SCM_OFS_MODE_A: next_rdata[7:0] = mode_a; // [R19]
			`SCM_OFS_MODE_B: next_rdata[7:0] = mode_b; // [R19]
			`SCM_OFS_STATUS: begin
				next_rdata[`SCM_S_RX9]  = received_ninth_bit; // [R18]
				next_rdata[`SCM_S_GAP]  = gap_hold & gap_apply;
				next_rdata[`SCM_S_TXOK] = tx_allow_o;
				next_rdata[`SCM_S_RXOK] = rx_allow_o;
				next_rdata[`SCM_S_CTS]  = cts_n_sync;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && !bus_done) begin
			avs_readdata_o <= next_rdata;
		end
	end

	// pins are asynchronous to the system clock
	scm_sync #(
		.W(2)
	) u_pin_sync (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.async_i ({clear_to_send_pin_n_i, serial_clock_pin_i}),
		.sync_o  (pin_sync)
	);

	assign cts_n_sync    = pin_sync[1];
	assign sclk_pin_sync = pin_sync[0];

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_pin_prev <= 1'b0;
			io_sclk_prev  <= 1'b0;
		end else begin
			sclk_pin_prev <= sclk_pin_sync;
			io_sclk_prev  <= io_sclk_i;
		end
	end

	assign sclk_pin_rise = sclk_pin_sync & ~sclk_pin_prev;
	assign io_sclk_rise  = io_sclk_i & ~io_sclk_prev;

	// the channel freezes in idle unless told to keep running [R07]
	assign channel_run = ~idle_mode_i | mode_b[`SCM_B_IDLE];

	// transfer clock source; synchronous mode looks only at clock direction [R05] [R06]
	always_comb begin
		next_tick = 1'b0;
		if (is_io) begin
			next_tick = clock_direction_i ? sclk_pin_rise : io_sclk_rise; // [R17]
		end else begin
			unique case (uart_clk)
				SCM_UCLK_TIMER: next_tick = timer_output_source_i;
				SCM_UCLK_BAUD:  next_tick = baud_tick_i;
				SCM_UCLK_SYS:   next_tick = 1'b1;
				SCM_UCLK_EXT:   next_tick = sclk_pin_rise;
			endcase
		end
		next_tick = next_tick & channel_run;
	end

	// gap only counts when this end drives the clock and buffering lets frames follow on [R12]
	assign gap_apply = is_io & ~clock_direction_i & buffered_i & (mode_b[`SCM_B_GAP_HI:`SCM_B_GAP_LO] != 3'h0);

	scm_gap_timer #(
		.CNT_W(7)
	) u_gap (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.start_i (tx_done_i & gap_apply), // [R11]
		.code_i  (mode_b[`SCM_B_GAP_HI:`SCM_B_GAP_LO]),
		.tick_i  (io_sclk_rise),
		.hold_o  (gap_hold)
	);

	// clear-to-send is active low; synchronous mode has no handshake [R02]
	assign cts_ok = is_io | ~mode_a[`SCM_A_HANDSHAKE_ENABLE] | ~cts_n_sync;

	// duplex blocks a direction only in synchronous mode [R08] [R09]
	// enables are sampled live, so software must settle modes first and not cut a character [R13] [R14] [R15] [R16]
	assign next_tx_allow = channel_run & mode_b[`SCM_B_TXE] & cts_ok & ~(gap_hold & gap_apply)
		& (~is_io | duplex[1]); // [R10]
	assign next_rx_allow = channel_run & mode_a[`SCM_A_RXE] & (~is_io | duplex[0]); // [R10]

	// wake-up filter only means something in 9-bit mode [R03]
	assign next_irq = rx_char_done_i & rx_allow_o
		& ~((frame == SCM_FRAME_U9) & mode_a[`SCM_A_WU] & ~rx_ninth_bit_i);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_allow_o  <= 1'b0;
			rx_allow_o  <= 1'b0;
			xfer_tick_o <= 1'b0;
			rx_irq_o    <= 1'b0;
		end else begin
			tx_allow_o  <= next_tx_allow;
			rx_allow_o  <= next_rx_allow;
			xfer_tick_o <= next_tick;
			rx_irq_o    <= next_irq; // [R03]
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frame_mode_o   <= SCM_FRAME_IO;
			fifo_config_o  <= SCM_DPX_OFF;
			tx_ninth_bit_o <= 1'b0;
		end else begin
			frame_mode_o   <= frame; // [R04]
			fifo_config_o  <= duplex; // [R08]
			tx_ninth_bit_o <= (frame == SCM_FRAME_U9) & mode_a[`SCM_A_TX9]; // [R01]
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			received_ninth_bit <= 1'b0;
		end else if (rx_char_done_i && rx_allow_o && frame == SCM_FRAME_U9) begin
			received_ninth_bit <= rx_ninth_bit_i; // [R18]
		end
	end

	// pin driver is registered so the enable and level change together
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			serial_clock_pin_o    <= 1'b0;
			serial_clock_pin_oe_o <= 1'b0;
		end else begin
			serial_clock_pin_o    <= io_sclk_i;
			serial_clock_pin_oe_o <= is_io & ~clock_direction_i & channel_run; // [R17]
		end
	end

	AST_TX_NINTH: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R01]
		(frame == SCM_FRAME_U9) |=> (tx_ninth_bit_o == $past(mode_a[`SCM_A_TX9])))
		else $error("ninth transmit bit not taken from mode register");

	AST_CTS_GATE: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R02]
		(!is_io && mode_a[`SCM_A_HANDSHAKE_ENABLE] && cts_n_sync) |=> !tx_allow_o)
		else $error("transmit allowed while clear-to-send is off");

	AST_WAKE_FILTER: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R03]
		(rx_char_done_i && frame == SCM_FRAME_U9 && mode_a[`SCM_A_WU] && !rx_ninth_bit_i) |=> !rx_irq_o)
		else $error("wake-up filter let a character through");

	AST_WAKE_OTHER: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R03]
		(rx_char_done_i && rx_allow_o && frame != SCM_FRAME_U9) |=> rx_irq_o)
		else $error("receive interrupt lost outside 9-bit mode");

	AST_TX_ENABLE: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R10]
		!mode_b[`SCM_B_TXE] |=> !tx_allow_o)
		else $error("transmit allowed while disabled");

	AST_IDLE_STOP: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R07]
		(idle_mode_i && !mode_b[`SCM_B_IDLE]) |=> (!tx_allow_o && !rx_allow_o && !xfer_tick_o))
		else $error("channel running in idle while set to stop");

	AST_IO_DUPLEX: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R08]
		(is_io && duplex == SCM_DPX_RX) |=> !tx_allow_o)
		else $error("receive-only synchronous mode allowed transmit");

	AST_UART_DUPLEX: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R09]
		(!is_io && duplex == SCM_DPX_OFF && channel_run && mode_a[`SCM_A_RXE]) |=> rx_allow_o)
		else $error("duplex field blocked reception in UART mode");

	AST_SCLK_DRIVE: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R17]
		(is_io && clock_direction_i) |=> !serial_clock_pin_oe_o)
		else $error("serial clock pin driven in clock input mode");

	AST_UPPER_ZERO: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R19]
		(avs_read_i && !bus_done && avs_address_i != `SCM_OFS_STATUS) |=> (avs_readdata_o[31:8] == 24'h000000))
		else $error("upper mode register bits read nonzero");

	AST_GAP_IGNORED: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R12]
		(!gap_apply && channel_run && mode_b[`SCM_B_TXE] && cts_ok && (!is_io || duplex[1])) |=> tx_allow_o)
		else $error("gap held transmit in a configuration where it does not apply");

endmodule

`default_nettype wire

// *** scm_pkg.sv ***
// types shared by the serial mode control block
package scm_pkg;

	typedef enum logic [1:0] {
		SCM_FRAME_IO = 2'b00,
		SCM_FRAME_U7 = 2'b01,
		SCM_FRAME_U8 = 2'b10,
		SCM_FRAME_U9 = 2'b11
	} scm_frame_t;

	typedef enum logic [1:0] {
		SCM_UCLK_TIMER = 2'b00,
		SCM_UCLK_BAUD  = 2'b01,
		SCM_UCLK_SYS   = 2'b10,
		SCM_UCLK_EXT   = 2'b11
	} scm_uclk_t;

	typedef enum logic [1:0] {
		SCM_DPX_OFF  = 2'b00,
		SCM_DPX_RX   = 2'b01,
		SCM_DPX_TX   = 2'b10,
		SCM_DPX_FULL = 2'b11
	} scm_duplex_t;

	typedef enum logic {
		SCM_GAP_IDLE = 1'b0,
		SCM_GAP_WAIT = 1'b1
	} scm_gap_state_t;

	// gap code to serial clock cycles: 0 -> none, n -> 2^(n-1)
	function automatic logic [6:0] scm_gap_cycles(input logic [2:0] code);
		logic [6:0] cyc;
		cyc = 7'h00;
		if (code != 3'h0) begin
			cyc = 7'h01 << (code - 3'h1);
		end
		return cyc;
	endfunction

endpackage

// *** scm_remote.sv ***
// remote serial device model driving the clear-to-send and serial clock pins
`timescale 1ns/1ps
`default_nettype none

module scm_remote (
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       hold_off_i,
	input  wire logic       burst_i,
	input  wire logic [3:0] half_i,
	output logic            clear_to_send_pin_n_o,
	output logic            sclk_o
);
	int cnt;

	// active low: high while the far end wants the sender to wait
	assign clear_to_send_pin_n_o = hold_off_i;

	// three clock pulses per burst; half period set per burst so the far end can be fast or slow
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 0;
		end else if (burst_i && cnt == 0) begin
			cnt <= 6 * half_i;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end

	// clock stands low between bursts
	assign sclk_o = (cnt != 0) && (((cnt - 1) / half_i) % 2 == 1);
endmodule

`default_nettype wire

// *** scm_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module scm_sync #(
	parameter int W = 1
) (
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta;

	if (W < 1) begin : g_bad_width
		$error("scm_sync: W must be at least 1");
	end

	// first stage feeds only the second stage
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule

`default_nettype wire

// *** serial_channel_mode_control_tb.sv ***
// self-checking testbench of the serial mode control block
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.svh"

module serial_channel_mode_control_tb;
	import scm_pkg::*;
	logic        clock_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hF, half = 4'h2;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic        clock_direction_i = 1'b0, idle_mode_i = 1'b0, buffered_i = 1'b0, timer_output_source_i = 1'b0;
	logic        baud_tick_i = 1'b0, io_sclk_i = 1'b0, tx_done_i = 1'b0, rx_char_done_i = 1'b0, rx_ninth_bit_i = 1'b0;
	logic        hold_off = 1'b0, burst = 1'b0, model_en = 1'b0, msclk, last = 1'b0;
	logic        avs_waitrequest_o, serial_clock_pin_o, serial_clock_pin_oe_o, tx_ninth_bit_o;
	logic        tx_allow_o, rx_allow_o, xfer_tick_o, rx_irq_o;
	wire logic   clear_to_send_pin_n_i, serial_clock_pin_i;
	scm_frame_t  frame_mode_o;
	scm_duplex_t fifo_config_o;
	int          mismatches = 0, checked = 0, ticks = 0;

	always #2 clock_i = ~clock_i;
	always @(posedge clock_i) if (xfer_tick_o === 1'b1) ticks <= ticks + 1;
	// undriven pin shows a changing level so no stale value can pass for a clock
	assign serial_clock_pin_i = serial_clock_pin_oe_o ? serial_clock_pin_o : (model_en ? msclk : ~last);
	always @(posedge clock_i) last <= serial_clock_pin_i;

	scm_mode_ctrl i_scm_mode_ctrl (.clock_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .clock_direction_i, .idle_mode_i, .buffered_i,
		.timer_output_source_i, .baud_tick_i, .io_sclk_i, .clear_to_send_pin_n_i, .serial_clock_pin_i,
		.serial_clock_pin_o, .serial_clock_pin_oe_o, .tx_done_i, .rx_char_done_i, .rx_ninth_bit_i, .frame_mode_o,
		.fifo_config_o, .tx_ninth_bit_o, .tx_allow_o, .rx_allow_o, .xfer_tick_o, .rx_irq_o);
	scm_remote i_scm_remote (.clock_i, .rstn_i, .hold_off_i(hold_off), .burst_i(burst), .half_i(half),
		.clear_to_send_pin_n_o(clear_to_send_pin_n_i), .sclk_o(msclk));

	task automatic wrap_up;
		if (mismatches == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// request stands until waitrequest is sampled low at a rising edge; read data is taken at that same edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clock_i);
			n++;
			if (n > 20) begin
				chk("bus answer", 32'h0, 32'h1);
				wrap_up();
			end
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, e, q);
	endtask

	// enables drop in the first two writes and rise last; mode A fields change while the old transmit enable still stands
	task automatic cfg(input logic [7:0] a, input logic [7:0] b);
		wr(`SCM_OFS_MODE_A, 32'(a & 8'hDF));
		wr(`SCM_OFS_MODE_B, 32'(b & 8'hEE));
		wr(`SCM_OFS_MODE_B, 32'(b & 8'hFE));
		wr(`SCM_OFS_MODE_A, 32'(a));
		cyc(6);
	endtask

	task automatic t_regs;
		rdc("mode a reset", `SCM_OFS_MODE_A, 32'h0);
		rdc("mode b reset", `SCM_OFS_MODE_B, 32'h0);
		wr(`SCM_OFS_MODE_A, 32'hFFFF_FF5A);
		rdc("mode a upper", `SCM_OFS_MODE_A, 32'h5A);
		avs_byteenable_i <= 4'hE;
		wr(`SCM_OFS_MODE_B, 32'h0000_00F0);
		avs_byteenable_i <= 4'hF;
		rdc("mode b lane", `SCM_OFS_MODE_B, 32'h0);
		wr(4'hC, 32'h0000_00FF);
		rdc("unmapped", 4'hC, 32'h0);
	endtask

	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			cfg(8'h81 | 8'(m << 2), 8'h00);
			chk("frame mode", 32'(m), 32'(frame_mode_o));
			chk("tx ninth", 32'(m == 3), 32'(tx_ninth_bit_o));
		end
	endtask

	task automatic t_enables;
		for (int m = 0; m < 4; m += 2) begin
			for (int d = 0; d < 4; d++) begin
				cfg(8'h20 | 8'(m << 2), 8'h10 | 8'(d << 5));
				chk("fifo config", 32'(d), 32'(fifo_config_o));
				chk("tx allow", 32'(m != 0 || d[1]), 32'(tx_allow_o));
				chk("rx allow", 32'(m != 0 || d[0]), 32'(rx_allow_o));
			end
		end
		cfg(8'h08, 8'h60);
		chk("both off", 32'h0, 32'({tx_allow_o, rx_allow_o}));
		idle_mode_i <= 1'b1;
		cfg(8'h28, 8'h10);
		chk("idle stop", 32'h0, 32'({tx_allow_o, rx_allow_o}));
		cfg(8'h28, 8'h90);
		chk("idle run", 32'h3, 32'({tx_allow_o, rx_allow_o}));
		idle_mode_i <= 1'b0;
	endtask

	task automatic t_cts;
		cfg(8'h48, 8'h10);
		hold_off <= 1'b1;
		cyc(6);
		chk("cts held", 32'h0, 32'(tx_allow_o));
		rdc("cts status", `SCM_OFS_STATUS, 32'h10);
		hold_off <= 1'b0;
		cyc(6);
		chk("cts clear", 32'h1, 32'(tx_allow_o));
		cfg(8'h08, 8'h10);
		hold_off <= 1'b1;
		cyc(6);
		chk("cts ignored", 32'h1, 32'(tx_allow_o));
		hold_off <= 1'b0;
	endtask

	task automatic rx_char(input logic b, input logic [31:0] e, input string what);
		int n;
		n = 0;
		rx_ninth_bit_i <= b;
		rx_char_done_i <= 1'b1;
		@(posedge clock_i);
		rx_char_done_i <= 1'b0;
		repeat (4) begin
			@(posedge clock_i);
			n += (rx_irq_o === 1'b1);
		end
		chk(what, e, 32'(n));
	endtask

	task automatic t_wake;
		cfg(8'h3C, 8'h00);
		rx_char(1'b0, 32'h0, "wake filtered");
		rx_char(1'b1, 32'h1, "wake pass");
		rdc("rx ninth", `SCM_OFS_STATUS, 32'h09);
		cfg(8'h38, 8'h00);
		rx_char(1'b0, 32'h1, "wake other mode");
		cfg(8'h1C, 8'h00);
		rx_char(1'b1, 32'h0, "rx blocked");
	endtask

	// per pass: 1 timer pulse, 2 baud ticks, 4 internal clock rises, 3 pin clock rises
	task automatic stim(input int h, output int n);
		int t0;
		t0 = ticks;
		repeat (2) begin
			timer_output_source_i <= 1'b1;
			cyc(1);
			timer_output_source_i <= 1'b0;
			repeat (2) begin
				cyc(2);
				baud_tick_i <= 1'b1;
				cyc(1);
				baud_tick_i <= 1'b0;
			end
			repeat (4) begin
				cyc(h);
				io_sclk_i <= 1'b1;
				cyc(h);
				io_sclk_i <= 1'b0;
			end
			half <= 4'(h);
			burst <= 1'b1;
			cyc(1);
			burst <= 1'b0;
			cyc(6 * h + 8);
		end
		n = ticks - t0;
	endtask

	task automatic t_clk;
		int n;
		model_en <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			cfg(8'h28 | 8'(s), 8'h10);
			if (s == 2) begin
				n = ticks;
				cyc(8);
				n = ticks - n;
			end else begin
				stim(s == 0 ? 2 : 5, n);
			end
			chk("uart clock", s == 0 ? 2 : s == 1 ? 4 : s == 2 ? 8 : 6, 32'(n));
		end
		clock_direction_i <= 1'b1;
		cfg(8'h21, 8'h70);
		chk("pin released", 32'h0, 32'(serial_clock_pin_oe_o));
		stim(2, n);
		chk("sync pin clock", 32'h6, 32'(n));
		model_en <= 1'b0;
		clock_direction_i <= 1'b0;
		cfg(8'h21, 8'h70);
		chk("pin driven", 32'h1, 32'(serial_clock_pin_oe_o));
		stim(2, n);
		chk("sync own clock", 32'h8, 32'(n));
		io_sclk_i <= 1'b1;
		cyc(2);
		chk("pin level", 32'h1, 32'(serial_clock_pin_o));
		io_sclk_i <= 1'b0;
	endtask

	task automatic gap_run(input logic [7:0] a, input logic [2:0] c, input int n);
		cfg(a, 8'h70 | 8'(c << 1));
		tx_done_i <= 1'b1;
		cyc(1);
		tx_done_i <= 1'b0;
		cyc(4);
		chk("gap start", 32'(n == 0), 32'(tx_allow_o));
		for (int i = 1; i <= n; i++) begin
			io_sclk_i <= 1'b1;
			cyc(3);
			io_sclk_i <= 1'b0;
			cyc(3);
			chk("gap end", 32'(i == n), 32'(tx_allow_o));
		end
	endtask

	task automatic t_gap;
		buffered_i <= 1'b1;
		gap_run(8'h00, 3'h0, 0);
		for (int c = 1; c < 8; c++) gap_run(8'h00, 3'(c), 1 << (c - 1));
		gap_run(8'h08, 3'h1, 0);
		clock_direction_i <= 1'b1;
		gap_run(8'h00, 3'h1, 0);
		clock_direction_i <= 1'b0;
		buffered_i <= 1'b0;
		gap_run(8'h00, 3'h1, 0);
	endtask

	initial begin
		cyc(20);
		rstn_i <= 1'b1;
		cyc(2);
		t_regs();
		t_modes();
		t_enables();
		t_cts();
		t_wake();
		t_clk();
		t_gap();
		wrap_up();
	end
endmodule

`default_nettype wire
